// [logic/lic_pkg.sv]
// lic_pkg: constants for the local interrupt controller
// assumes one 10 MHz clock and a core that reaches the block through its mem port
package lic_pkg;
  localparam logic [31:0] BASE_RESET   = 32'hfee00000;
  localparam int          REGION_BITS  = 12;
  // register offsets inside the 4 KB region, 16-byte aligned
  localparam logic [11:0] OFF_ID       = 12'h020;
  localparam logic [11:0] OFF_CTRL     = 12'h0f0;
  localparam logic [11:0] OFF_ERR      = 12'h280;
  localparam logic [11:0] OFF_CMD_LO   = 12'h300;
  localparam logic [11:0] OFF_CMD_HI   = 12'h310;
  localparam logic [11:0] OFF_VT_BASE  = 12'h320;
  localparam logic [11:0] OFF_TMR_INIT = 12'h380;
  localparam logic [11:0] OFF_TMR_CUR  = 12'h390;
  // source indices; vector-table entry i sits at OFF_VT_BASE + 16*i
  localparam int SRC_TIMER = 0;
  localparam int SRC_THERM = 1;
  localparam int SRC_PERF  = 2;
  localparam int SRC_PINA  = 3;
  localparam int SRC_PINB  = 4;
  localparam int SRC_ERR   = 5;
  localparam int NUM_SRC   = 6;
  // field positions
  localparam int MODE_LSB     = 8;
  localparam int BUSY_BIT     = 12;
  localparam int TRIG_BIT     = 15;
  localparam int MASK_BIT     = 16;
  localparam int PERIODIC_BIT = 17;
  localparam int SELF_BIT     = 18;
  localparam int ENABLE_BIT   = 8;
  localparam int DEST_LSB     = 24;
  // delivery modes
  localparam logic [2:0] MODE_FIXED   = 3'h0;
  localparam logic [2:0] MODE_SMI     = 3'h2;
  localparam logic [2:0] MODE_NMI     = 3'h4;
  localparam logic [2:0] MODE_INIT    = 3'h5;
  localparam logic [2:0] MODE_STARTUP = 3'h6;
  localparam logic [7:0] NMI_VECTOR   = 8'h02;
  // reset values
  localparam logic [31:0] VT_RESET    = 32'h00010000;
  localparam logic [31:0] CTRL_RESET  = 32'h00000000;
  // wire-bus frame: dest, vector, mode, trigger, two bits per wire clock
  localparam int WIRE_BITS  = 20;
  localparam int WIRE_SLOTS = WIRE_BITS / 2;
endpackage : lic_pkg

// [logic/lic_local_irq_ctrl.sv]
// lic_local_irq_ctrl: per-processor local interrupt controller
// assumes the core drives the mem port and acks coreReq; pins are asynchronous
//
// How it works
// - two pins, edge or level trigger
// - each local source owns one table entry
// - nmi entry on pin b delivers vector 2
// - command low write sends a message
// - messages may target self
// - received message delivered without software
// - io messages share the receive path
// - timer raises interrupt at count end
// - unmapped access raises error interrupt
// - counter overflow raises its entry
// - thermal trip raises its entry
// - disabled: core takes legacy controller directly
// - wire variant uses three-wire bus
// - system variant sends on system bus
// - registers memory mapped, plain loads/stores
// - nmi, init, smi, startup modes carried
// - 4 KB region, relocatable base
// - 32-bit registers on 128-bit alignment
`timescale 1ns/10ps
`default_nettype none
module lic_local_irq_ctrl #(
  parameter logic [7:0] CTRL_ID = 8'h5a  // arbitrary identity value
) (
  input  wire logic        clock,
  input  wire logic        rst,
  // core register access
  input  wire logic        memValid,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [31:0] baseAddr,
  output logic      [31:0] memRdata,
  output logic             memReady,
  // local sources
  input  wire logic        localIrqPinA,
  input  wire logic        localIrqPinB,
  input  wire logic        perfOverflow,
  input  wire logic        thermalTrip,
  // delivery to core
  output logic             coreReq,
  output logic      [7:0]  coreVector,
  output logic      [2:0]  coreMode,
  input  wire logic        coreAck,
  // legacy cascaded controller
  input  wire logic        legacyReq,
  input  wire logic [7:0]  legacyVector,
  output logic             legacyAck,
  // outgoing messages, system bus variant
  input  wire logic        wireVariant,
  output logic             msgOutValid,
  output logic      [7:0]  msgOutDest,
  output logic      [7:0]  msgOutVector,
  output logic      [2:0]  msgOutMode,
  output logic             msgOutLevel,
  input  wire logic        msgOutReady,
  // incoming messages
  input  wire logic        msgInValid,
  input  wire logic [7:0]  msgInVector,
  input  wire logic [2:0]  msgInMode,
  output logic             msgInReady,
  // three-wire bus, open drain data
  output logic             wireClk,
  output logic      [1:0]  wireData,
  output logic      [1:0]  wireDataOe
);
  import lic_pkg::*;

  function automatic logic [7:0] pickVec(input logic [31:0] e);
    pickVec = (e[MODE_LSB+:3] == MODE_NMI) ? NMI_VECTOR : e[7:0];
  endfunction : pickVec

  logic [2:0]  pinASync_q, pinBSync_q;
  logic        pinA_q, pinB_q;
  logic [31:0] vt_q [NUM_SRC];
  logic [31:0] ctrl_q, errStat_q, cmdLo_q, cmdHi_q, tmrInit_q, tmrCur_q;
  logic [NUM_SRC-1:0] pend_q, ev, grant;
  logic        rxFull_q;
  logic [7:0]  rxVector_q;
  logic [2:0]  rxMode_q;
  logic [WIRE_BITS-1:0] wireShift_q;
  logic [3:0]  wireSlot_q;
  logic        wirePhase_q, wireBusy_q;
  logic        enabled, access, hit, wrAcc, rdAcc, mapped, errEv, selfTake, extTake;
  logic        cmdStart, rxGrant, pickAny, rxFull_d;
  logic [11:0] off;
  logic [2:0]  vtIdx;
  logic [31:0] pickEntry;

  assign enabled = ctrl_q[ENABLE_BIT];
  // decode against relocatable 4 KB base
  assign hit    = memAddr[31:REGION_BITS] == baseAddr[31:REGION_BITS];
  assign access = memValid & hit & ~memReady;
  assign off    = memAddr[REGION_BITS-1:0];
  assign wrAcc  = access & memWrite;
  assign rdAcc  = access & ~memWrite;
  assign vtIdx  = 3'((off - OFF_VT_BASE) >> 4);
  // only 16-byte aligned words are implemented
  assign mapped = (off[3:0] == 4'h0) &&
                  (off == OFF_ID || off == OFF_CTRL || off == OFF_ERR ||
                   off == OFF_CMD_LO || off == OFF_CMD_HI || off == OFF_TMR_INIT ||
                   off == OFF_TMR_CUR ||
                   (off >= OFF_VT_BASE && off < OFF_VT_BASE + 12'(16 * NUM_SRC)));
  // unmapped access is an internal error
  assign errEv  = access & ~mapped;

  // three-stage sync, change taken when stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      pinASync_q <= 3'h0;
      pinBSync_q <= 3'h0;
      pinA_q     <= 1'b0;
      pinB_q     <= 1'b0;
    end else begin
      pinASync_q <= {pinASync_q[1:0], localIrqPinA};
      pinBSync_q <= {pinBSync_q[1:0], localIrqPinB};
      if (pinASync_q[1] == pinASync_q[2]) pinA_q <= pinASync_q[2];
      if (pinBSync_q[1] == pinBSync_q[2]) pinB_q <= pinBSync_q[2];
    end
  end

  always_comb begin
    ev = '0;
    ev[SRC_TIMER] = (tmrCur_q == 32'h1);
    ev[SRC_THERM] = thermalTrip;
    ev[SRC_PERF]  = perfOverflow;
    // level holds request, edge takes rising change
    ev[SRC_PINA]  = vt_q[SRC_PINA][TRIG_BIT] ? pinA_q :
                    (pinASync_q[1] == pinASync_q[2]) & pinASync_q[2] & ~pinA_q;
    ev[SRC_PINB]  = vt_q[SRC_PINB][TRIG_BIT] ? pinB_q :
                    (pinBSync_q[1] == pinBSync_q[2]) & pinBSync_q[2] & ~pinB_q;
    ev[SRC_ERR]   = errEv;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q    <= CTRL_RESET;
      cmdHi_q   <= 32'h0;
      tmrInit_q <= 32'h0;
      for (int i = 0; i < NUM_SRC; i++) vt_q[i] <= VT_RESET;
    end else if (wrAcc) begin
      if (off == OFF_CTRL) ctrl_q <= memWdata;
      if (off == OFF_CMD_HI) cmdHi_q <= memWdata;
      if (off == OFF_TMR_INIT) tmrInit_q <= memWdata;
      if (mapped && off >= OFF_VT_BASE && off < OFF_TMR_INIT) vt_q[vtIdx] <= memWdata;
    end
  end

  // timer counts down, optional periodic reload
  always_ff @(posedge clock) begin
    if (rst) tmrCur_q <= 32'h0;
    else if (wrAcc && off == OFF_TMR_INIT) tmrCur_q <= memWdata;
    else if (tmrCur_q == 32'h1 && vt_q[SRC_TIMER][PERIODIC_BIT]) tmrCur_q <= tmrInit_q;
    else if (tmrCur_q != 32'h0) tmrCur_q <= tmrCur_q - 32'h1;
  end

  // sticky error status, new error wins over clear
  always_ff @(posedge clock) begin
    if (rst) errStat_q <= 32'h0;
    else errStat_q <= (wrAcc && off == OFF_ERR ? 32'h0 : errStat_q) |
                      {31'h0, errEv};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      memRdata <= 32'h0;
      memReady <= 1'b0;
    end else begin
      memReady <= access;
      memRdata <= 32'h0;
      if (rdAcc) begin
        case (off)
          OFF_ID:       memRdata <= {24'h0, CTRL_ID};
          OFF_CTRL:     memRdata <= ctrl_q;
          OFF_ERR:      memRdata <= errStat_q;
          OFF_CMD_LO:   memRdata <= cmdLo_q;
          OFF_CMD_HI:   memRdata <= cmdHi_q;
          OFF_TMR_INIT: memRdata <= tmrInit_q;
          OFF_TMR_CUR:  memRdata <= tmrCur_q;
          default:      memRdata <= mapped ? vt_q[vtIdx] : 32'h0;
        endcase
      end
    end
  end

  // arbitration: lowest source index first, received message last
  always_comb begin
    grant     = '0;
    pickAny   = 1'b0;
    pickEntry = 32'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend_q[i] && !pickAny) begin
        grant[i]  = 1'b1;
        pickAny   = 1'b1;
        pickEntry = vt_q[i];
      end
    end
    if (coreReq || !enabled) begin
      grant   = '0;
      pickAny = 1'b0;
    end
  end
  assign rxGrant = enabled & ~coreReq & ~pickAny & rxFull_q;

  // pending flags; an event in the grant cycle stays pending
  always_ff @(posedge clock) begin
    if (rst) pend_q <= '0;
    else for (int i = 0; i < NUM_SRC; i++)
      pend_q[i] <= (pend_q[i] & ~grant[i]) | (ev[i] & ~vt_q[i][MASK_BIT]);
  end

  // request and vector held until core ack
  always_ff @(posedge clock) begin
    if (rst) begin
      coreReq    <= 1'b0;
      coreVector <= 8'h0;
      coreMode   <= MODE_FIXED;
      legacyAck  <= 1'b0;
    end else begin
      legacyAck <= 1'b0;
      if (coreReq && coreAck) begin
        coreReq   <= 1'b0;
        legacyAck <= ~enabled;
      end else if (!coreReq && !enabled && legacyReq && !legacyAck) begin
        // disabled controller passes legacy requests through
        coreReq    <= 1'b1;
        coreVector <= legacyVector;
        coreMode   <= MODE_FIXED;
      end else if (pickAny) begin
        coreReq    <= 1'b1;
        coreVector <= pickVec(pickEntry);
        // special modes carried to the core
        coreMode   <= pickEntry[MODE_LSB+:3];
      end else if (rxGrant) begin
        coreReq    <= 1'b1;
        coreVector <= pickVec({21'h0, rxMode_q, rxVector_q});
        coreMode   <= rxMode_q;
      end
    end
  end

  // command low write starts a message unless one is in flight
  assign cmdStart = wrAcc & (off == OFF_CMD_LO) & ~cmdLo_q[BUSY_BIT];
  // self shorthand loops into own receive slot
  assign extTake  = msgInValid & msgInReady;
  assign selfTake = cmdLo_q[BUSY_BIT] & cmdLo_q[SELF_BIT] & ~rxFull_q & ~extTake;
  assign rxFull_d = (rxFull_q & ~rxGrant) | extTake | selfTake;

  always_ff @(posedge clock) begin
    if (rst) cmdLo_q <= 32'h0;
    else if (cmdStart) cmdLo_q <= memWdata | (32'h1 << BUSY_BIT);
    else if (selfTake || (msgOutValid && msgOutReady) ||
             (wireBusy_q && wirePhase_q && wireSlot_q == 4'(WIRE_SLOTS - 1)))
      cmdLo_q[BUSY_BIT] <= 1'b0;
  end

  // receive slot delivered to core by hardware
  // io controller messages enter the same slot
  always_ff @(posedge clock) begin
    if (rst) begin
      rxFull_q   <= 1'b0;
      rxVector_q <= 8'h0;
      rxMode_q   <= MODE_FIXED;
      msgInReady <= 1'b0;
    end else begin
      rxFull_q   <= rxFull_d;
      msgInReady <= ~rxFull_d & ~extTake;
      if (extTake) begin
        rxVector_q <= msgInVector;
        rxMode_q   <= msgInMode;
      end else if (selfTake) begin
        rxVector_q <= cmdLo_q[7:0];
        rxMode_q   <= cmdLo_q[MODE_LSB+:3];
      end
    end
  end

  // system bus variant: message held until ready
  always_ff @(posedge clock) begin
    if (rst) begin
      msgOutValid  <= 1'b0;
      msgOutDest   <= 8'h0;
      msgOutVector <= 8'h0;
      msgOutMode   <= MODE_FIXED;
      msgOutLevel  <= 1'b0;
    end else if (msgOutValid) begin
      if (msgOutReady) msgOutValid <= 1'b0;
    end else if (cmdStart && !memWdata[SELF_BIT] && !wireVariant) begin
      msgOutValid  <= 1'b1;
      msgOutDest   <= cmdHi_q[DEST_LSB+:8];
      msgOutVector <= memWdata[7:0];
      msgOutMode   <= memWdata[MODE_LSB+:3];
      msgOutLevel  <= memWdata[TRIG_BIT];
    end
  end

  // wire variant: two bits per wire clock, data pulled low only
  always_ff @(posedge clock) begin
    if (rst) begin
      wireBusy_q  <= 1'b0;
      wireShift_q <= '0;
      wireSlot_q  <= 4'h0;
      wirePhase_q <= 1'b0;
      wireClk     <= 1'b0;
      wireData    <= 2'h0;
      wireDataOe  <= 2'h0;
    end else if (!wireBusy_q) begin
      wireClk    <= 1'b0;
      wireDataOe <= 2'h0;
      if (cmdStart && !memWdata[SELF_BIT] && wireVariant) begin
        wireBusy_q  <= 1'b1;
        wireShift_q <= {cmdHi_q[DEST_LSB+:8], memWdata[7:0],
                        memWdata[MODE_LSB+:3], memWdata[TRIG_BIT]};
        wireSlot_q  <= 4'h0;
        wirePhase_q <= 1'b0;
      end
    end else begin
      wirePhase_q <= ~wirePhase_q;
      wireClk     <= ~wirePhase_q;
      if (!wirePhase_q) begin
        wireDataOe  <= ~wireShift_q[WIRE_BITS-1 -: 2];
        wireShift_q <= {wireShift_q[WIRE_BITS-3:0], 2'b00};
      end else if (wireSlot_q == 4'(WIRE_SLOTS - 1)) begin
        wireBusy_q <= 1'b0;
      end else begin
        wireSlot_q <= wireSlot_q + 4'h1;
      end
    end
  end

endmodule : lic_local_irq_ctrl
`default_nettype wire

// [bench/lic_core_model.sv]
// lic_core_model: core and system-bus acceptor facing the controller
// assumes one clock; slow adds a three-cycle wait before each accept
`timescale 1ns/10ps
`default_nettype none
module lic_core_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic slow,
  // core delivery
  input  wire logic coreReq,
  output var  logic coreAck,
  // outgoing messages
  input  wire logic msgOutValid,
  output var  logic msgOutReady
);
  logic [1:0] coreWaitQ;
  logic [1:0] busWaitQ;

  always_ff @(posedge clock) begin
    if (rst || !coreReq || coreAck) begin
      coreAck   <= 1'b0;
      coreWaitQ <= slow ? 2'h3 : 2'h0;
    end else if (coreWaitQ != 2'h0) coreWaitQ <= coreWaitQ - 2'h1;
    else coreAck <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (rst || !msgOutValid || msgOutReady) begin
      msgOutReady <= 1'b0;
      busWaitQ    <= slow ? 2'h3 : 2'h0;
    end else if (busWaitQ != 2'h0) busWaitQ <= busWaitQ - 2'h1;
    else msgOutReady <= 1'b1;
  end
endmodule : lic_core_model
`default_nettype wire

// [bench/lic_local_irq_ctrl_asserts.sv]
// lic_local_irq_ctrl_asserts: port-level checks of the controller
// assumes the single clock domain and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module lic_local_irq_ctrl_asserts (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port
  input  wire logic        memValid,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] baseAddr,
  input  wire logic [31:0] memRdata,
  input  wire logic        memReady,
  // core delivery
  input  wire logic        coreReq,
  input  wire logic [7:0]  coreVector,
  input  wire logic [2:0]  coreMode,
  input  wire logic        coreAck,
  // messages
  input  wire logic        msgOutValid,
  input  wire logic [7:0]  msgOutVector,
  input  wire logic [2:0]  msgOutMode,
  input  wire logic        msgOutReady,
  input  wire logic [1:0]  wireData,
  input  wire logic        wireClk,
  input  wire logic [1:0]  wireDataOe
);
  import lic_pkg::*;
  logic hit;
  assign hit = memAddr[31:12] == baseAddr[31:12];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_READY_NEXT: assert property (memValid && hit && !memReady |=> memReady)
    else $error("region access not answered next cycle");
  AST_READY_PULSE: assert property (memReady |=> !memReady)
    else $error("ready longer than one cycle");
  AST_NO_FOREIGN: assert property (memValid && !hit && !memReady |=> !memReady)
    else $error("answer outside the region");
  AST_RDATA_IDLE: assert property (!memReady |-> memRdata == 32'h0)
    else $error("read data outside ready cycle");
  AST_REQ_HOLD: assert property (coreReq && !coreAck |=> coreReq && $stable(coreVector) && $stable(coreMode))
    else $error("core request changed before accept");
  AST_REQ_DROP: assert property (coreReq && coreAck |=> !coreReq)
    else $error("core request kept after accept");
  AST_NMI_TWO: assert property (coreReq && coreMode == MODE_NMI |-> coreVector == NMI_VECTOR)
    else $error("nmi delivered with wrong vector");
  AST_MSG_HOLD: assert property (msgOutValid && !msgOutReady |=> msgOutValid && $stable(msgOutVector) && $stable(msgOutMode))
    else $error("message changed before accept");
  AST_MSG_DROP: assert property (msgOutValid && msgOutReady |=> !msgOutValid)
    else $error("message kept after accept");
  AST_WIRE_LOW: assert property (wireData == 2'h0)
    else $error("wire data driven high");
  AST_WIRE_OE_STEADY: assert property (wireClk |=> $stable(wireDataOe))
    else $error("wire data moved while wire clock high");

  cover property (coreReq && coreAck && coreMode == MODE_NMI);
  cover property (msgOutValid && msgOutReady);
  cover property (memReady && memRdata != 32'h0);
endmodule : lic_local_irq_ctrl_asserts
bind lic_local_irq_ctrl lic_local_irq_ctrl_asserts u_asserts (.*);
`default_nettype wire

// [bench/lic_testbench.sv]
// testbench: self-checking scenarios for the local interrupt controller
// assumes the core model answers deliveries and outgoing messages
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lic_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identity value
  localparam logic [2:0] MODES [5] = '{MODE_FIXED, MODE_SMI, MODE_NMI, MODE_INIT, MODE_STARTUP};
  logic        clock = 1'b0;
  logic        rst, slow, memValid, memWrite, memReady, localIrqPinA, localIrqPinB;
  logic        perfOverflow, thermalTrip, coreReq, coreAck, legacyReq, legacyAck;
  logic        wireVariant, msgOutValid, msgOutLevel, msgOutReady, msgInValid, msgInReady, wireClk;
  logic [31:0] memAddr, memWdata, baseAddr, memRdata, rd;
  logic [7:0]  coreVector, legacyVector, msgOutDest, msgOutVector, msgInVector;
  logic [2:0]  coreMode, msgOutMode, msgInMode;
  logic [1:0]  wireData, wireDataOe;
  int          num_errors = 0;
  int          total_checks = 0;
  int          legacySeen = 0;
  int          wireRises = 0;
  logic [19:0] wireFrame = '0;

  lic_local_irq_ctrl #(.CTRL_ID(ID_VAL)) dut (.*);
  lic_core_model model (.*);

  always #50 clock = ~clock;
  always @(posedge legacyAck) legacySeen++;
  always @(posedge wireClk) wireRises++;
  always @(negedge wireClk) wireFrame = {wireFrame[17:0], wireDataOe};

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [11:0] entry(input int s);
    return OFF_VT_BASE + 12'(16 * s);
  endfunction : entry

  task automatic access(input logic wr, input logic [11:0] off, input logic [31:0] wd);
    int n;
    @(negedge clock);
    memValid = 1'b1;
    memWrite = wr;
    memAddr = {BASE_RESET[31:12], off};
    memWdata = wd;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (memReady !== 1'b1 && n < 20);
    rd = memRdata;
    check({31'h0, memReady}, 32'h1);
    @(negedge clock);
    memValid = 1'b0;
    memWdata = ~wd;
    memAddr = ~memAddr;
  endtask : access

  task automatic expect_core(input logic [7:0] vec, input logic [2:0] mode);
    int n;
    n = 0;
    while (coreReq !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    legacyReq = 1'b0;
    legacyVector = ~legacyVector;
    check({31'h0, coreReq}, 32'h1);
    check({24'h0, coreVector}, {24'h0, vec});
    check({29'h0, coreMode}, {29'h0, mode});
    while (coreReq === 1'b1 && n < 90) begin
      @(negedge clock);
      n++;
    end
    check({31'h0, coreReq}, 32'h0);
  endtask : expect_core

  task automatic fire(input int s);
    @(negedge clock);
    thermalTrip = (s == SRC_THERM);
    perfOverflow = (s == SRC_PERF);
    localIrqPinA = (s == SRC_PINA);
    localIrqPinB = (s == SRC_PINB);
    repeat (s >= SRC_PINA ? 4 : 1) @(negedge clock);
    {thermalTrip, perfOverflow, localIrqPinA, localIrqPinB} = 4'h0;
  endtask : fire

  task automatic test_legacy();
    @(negedge clock);
    legacyVector = 8'h28;
    legacyReq = 1'b1;
    expect_core(8'h28, MODE_FIXED);
    repeat (3) @(negedge clock);
    check({31'h0, legacySeen > 0}, 32'h1);
  endtask : test_legacy

  task automatic test_table();
    for (int i = 0; i < NUM_SRC; i++) begin
      access(1'b0, entry(i), 32'h0);
      check(rd, VT_RESET);
    end
    access(1'b0, OFF_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    access(1'b1, entry(SRC_PINA), 32'h0001_8533);
    access(1'b0, entry(SRC_PINA), 32'h0);
    check(rd, 32'h0001_8533);
    @(negedge clock);
    memValid = 1'b1;
    memAddr = 32'h0;
    repeat (4) begin
      @(negedge clock);
      check({31'h0, memReady}, 32'h0);
    end
    memValid = 1'b0;
  endtask : test_table

  task automatic test_error();
    access(1'b1, OFF_CTRL, 32'h1 << ENABLE_BIT);
    access(1'b1, entry(SRC_ERR), 32'h4e);
    access(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    expect_core(8'h4e, MODE_FIXED);
    access(1'b0, OFF_ERR, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
  endtask : test_error

  task automatic test_local();
    logic [2:0] m;
    for (int s = SRC_THERM; s <= SRC_PINB; s++) begin
      slow = s[0];
      m = (s == SRC_PINB) ? MODE_NMI : MODE_FIXED;
      access(1'b1, entry(s), {21'h0, m, 8'h40 + 8'(s)});
      fire(s);
      expect_core((s == SRC_PINB) ? NMI_VECTOR : 8'h40 + 8'(s), m);
      access(1'b1, entry(s), VT_RESET);
    end
    access(1'b1, entry(SRC_PINA), 32'h0000_8047);
    localIrqPinA = 1'b1;
    repeat (2) expect_core(8'h47, MODE_FIXED);
    access(1'b1, entry(SRC_PINA), VT_RESET);
    localIrqPinA = 1'b0;
    fire(SRC_THERM);
    repeat (12) @(negedge clock);
    check({31'h0, coreReq}, 32'h0);
  endtask : test_local

  task automatic test_timer();
    access(1'b1, entry(SRC_TIMER), 32'h35);
    access(1'b1, OFF_TMR_INIT, 32'h8);
    expect_core(8'h35, MODE_FIXED);
    access(1'b1, entry(SRC_TIMER), VT_RESET);
  endtask : test_timer

  task automatic test_send();
    int n;
    for (int i = 0; i < 5; i++) begin
      slow = i[0];
      access(1'b1, OFF_CMD_HI, 32'h0700_0000);
      access(1'b1, OFF_CMD_LO, {16'h0, i[0], 4'h0, MODES[i], 8'h50});
      n = 0;
      while (msgOutValid !== 1'b1 && n < 20) begin
        @(negedge clock);
        n++;
      end
      check({24'h0, msgOutDest}, 32'h7);
      check({29'h0, msgOutMode}, {29'h0, MODES[i]});
      check({24'h0, msgOutVector}, 32'h50);
      check({31'h0, msgOutLevel}, {31'h0, i[0]});
      while (msgOutValid === 1'b1 && n < 40) begin
        @(negedge clock);
        n++;
      end
    end
  endtask : test_send

  task automatic test_receive();
    int n;
    access(1'b1, OFF_CMD_LO, 32'h0004_0066);
    expect_core(8'h66, MODE_FIXED);
    @(negedge clock);
    msgInValid = 1'b1;
    msgInVector = 8'h5c;
    msgInMode = MODE_FIXED;
    n = 0;
    while (msgInReady !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    check({31'h0, msgInReady}, 32'h1);
    @(negedge clock);
    msgInValid = 1'b0;
    msgInVector = ~msgInVector;
    check({31'h0, msgInReady}, 32'h0);
    expect_core(8'h5c, MODE_FIXED);
  endtask : test_receive

  task automatic test_wire();
    wireVariant = 1'b1;
    wireRises = 0;
    access(1'b1, OFF_CMD_HI, 32'h0900_0000);
    access(1'b1, OFF_CMD_LO, 32'h31);
    repeat (40) @(negedge clock);
    check(wireRises, WIRE_SLOTS);
    check({12'h0, wireFrame}, {12'h0, ~{8'h09, 8'h31, 4'h0}});
    check({31'h0, msgOutValid}, 32'h0);
    wireVariant = 1'b0;
  endtask : test_wire

  initial begin
    rst = 1'b1;
    slow = 1'b0;
    {memValid, memWrite, localIrqPinA, localIrqPinB, perfOverflow, thermalTrip} = '0;
    {legacyReq, wireVariant, msgInValid} = '0;
    {memAddr, memWdata, legacyVector, msgInVector, msgInMode} = '0;
    baseAddr = BASE_RESET;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    test_legacy();
    test_table();
    test_error();
    test_local();
    test_timer();
    test_send();
    test_receive();
    test_wire();
    complete_run();
  end

  initial begin
    #1_000_000;
    num_errors++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
